// ==== cbt_pkg.sv ====
`default_nettype none
package cbt_pkg;
	// Register map, byte addresses on the plain port
	localparam logic [15:0] ADDR_PRESCALE = 16'h231C;
	localparam logic [15:0] ADDR_STATUS = 16'h231D;
	localparam logic [15:0] ADDR_TWO_LOW = 16'h231E;
	localparam logic [15:0] ADDR_TWO_HIGH = 16'h231F;
	// Field positions
	localparam int SAM_POS = 7;
	localparam int SEG2_LSB = 4;
	localparam int SEG1_LSB = 0;
	localparam int SJW_LSB = 0;
	localparam int STAT_BIT_POS = 0;
	localparam int STAT_PHASE_LSB = 1;
	localparam int STAT_RESYNC_POS = 3;
	localparam int STAT_BAD_POS = 4;
	// Reset values
	localparam logic [7:0] PRESCALE_RST = 8'h00;
	localparam logic [7:0] TWO_LOW_RST = 8'h00;
	localparam logic [7:0] TWO_HIGH_RST = 8'h00;
	// Timing counts in CAN clock cycles or quanta
	localparam int IPT_CYCLES = 4;
	localparam int SEG2_MIN_NO_PRESCALE = 4;
	localparam int SEG2_MIN = 2;
	localparam int SYNC_QUANTA = 1;

	typedef enum logic [1:0] {
		CBT_SYNC,
		CBT_SEG1,
		CBT_SEG2
	} cbt_phase_type;

	typedef struct packed {
		logic [7:0] brp;
		logic sam;
		logic [2:0] seg2;
		logic [3:0] seg1;
		logic [1:0] resync_jump_width;
	} cbt_cfg_type;

	typedef struct packed {
		logic [7:0] count;
		logic tick;
	} cbt_presc_type;

	typedef struct packed {
		logic [2:0] hist;
	} cbt_samp_type;

	typedef struct packed {
		cbt_cfg_type cfg;
		logic rxMeta;
		logic rxSync;
		logic rxPrev;
		logic pendEdge;
		cbt_phase_type phase;
		logic [4:0] cnt;
		logic [2:0] seg1Extra;
		logic [2:0] seg2Cut;
		logic resynced;
		logic rxBit;
		logic samplePulse;
		logic bitStart;
		logic cfgBad;
		logic [7:0] rdData;
	} cbt_main_type;
endpackage
`default_nettype wire

// ==== cbt_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_prescaler #(
	parameter int BRP_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic restart,
	input wire logic [BRP_W-1:0] brp,
	// Quantum tick
	output logic tick
);
	cbt_pkg::cbt_presc_type s_r, s_nxt;

	// quantum is brp plus one clocks
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = !restart && (s_r.count == brp);
		if (restart || s_r.count == brp) begin
			s_nxt.count = '0;
		end else begin
			s_nxt.count = s_r.count + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

	AST_TQ_SPACING: assert property (@(posedge clk) disable iff (!resetn)
		(tick && brp == 8'h01 && !restart)
		|=> (!tick ##1 (tick || $past(restart) || $past(brp) != 8'h01)))
		else $error("quantum tick spacing wrong for prescale one");
endmodule
`default_nettype wire

// ==== cbt_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_sampler (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus samples
	input wire logic shiftEn,
	input wire logic rxIn,
	// Majority of the last three samples
	output logic vote
);
	cbt_pkg::cbt_samp_type s_r, s_nxt;

	function automatic logic majority(input logic [2:0] v);
		majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	always_comb begin
		s_nxt = s_r;
		if (shiftEn) begin
			s_nxt.hist = {s_r.hist[1:0], rxIn};
		end
	end

	// Recessive history so a fresh start votes high
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_r <= 3'h7;
		end else begin
			s_r <= s_nxt;
		end
	end

	// vote over last three samples, the current one included
	assign vote = majority({s_r.hist[1:0], rxIn});

	AST_HIST_SHIFT: assert property (@(posedge clk) disable iff (!resetn)
		shiftEn |=> (s_r.hist[0] == $past(rxIn)))
		else $error("sample history did not take the bus level");
endmodule
`default_nettype wire

// ==== cbt_bit_timing.sv ====
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Jump width code 00..11 allows one to four quanta of correction.
// - Quantum lasts prescale value plus one CAN clock cycles.
// - Bit is sync segment, first segment, second segment; sync is one quantum.
// - Each segment lasts its field value plus one quanta.
// - Reading a bit needs four clocks; second segment must cover that.
// - Synchronisation happens only on recessive to dominant bus edges.
// - Sample select set takes majority of the last three samples.
// - Sample select only acts with prescale above zero; else single sample.
// - All nodes share one baud rate set by prescale and segments.
// - Jump width sits in bits 9:8, read/write, resets to one quantum.
module cbt_bit_timing (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	// Bus side
	input wire logic canRx,
	input wire logic hardSyncEn,
	// Bit stream to the protocol logic
	output logic rxBit,
	output logic samplePulse,
	output logic bitStart
);
	cbt_pkg::cbt_main_type s_r, s_nxt;
	logic tqTick;
	logic vote;
	logic fall;
	logic hardSync;
	logic [2:0] sjwQ;
	logic [4:0] seg1Limit;
	logic [4:0] seg2Len;
	logic [4:0] seg2Limit;
	logic useMajority;
	logic [11:0] seg2Clks;

	function automatic logic [2:0] minQ(input logic [4:0] a, input logic [2:0] b);
		minQ = (a < {2'h0, b}) ? a[2:0] : b;
	endfunction

	function automatic logic [7:0] readMux(input cbt_pkg::cbt_main_type s,
			input logic [15:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			cbt_pkg::ADDR_PRESCALE: v = s.cfg.brp;
			cbt_pkg::ADDR_TWO_LOW: begin
				v[cbt_pkg::SAM_POS] = s.cfg.sam;
				v[cbt_pkg::SEG2_LSB +: 3] = s.cfg.seg2;
				v[cbt_pkg::SEG1_LSB +: 4] = s.cfg.seg1;
			end
			cbt_pkg::ADDR_TWO_HIGH: v[cbt_pkg::SJW_LSB +: 2] = s.cfg.resync_jump_width;
			cbt_pkg::ADDR_STATUS: begin
				v[cbt_pkg::STAT_BIT_POS] = s.rxBit;
				v[cbt_pkg::STAT_PHASE_LSB +: 2] = s.phase;
				v[cbt_pkg::STAT_RESYNC_POS] = s.resynced;
				v[cbt_pkg::STAT_BAD_POS] = s.cfgBad;
			end
			default: v = 8'h00;
		endcase
		readMux = v;
	endfunction

	assign sjwQ = {1'b0, s_r.cfg.resync_jump_width} + 3'h1;
	// field value plus one, first segment lengthened by resync
	assign seg1Limit = {1'b0, s_r.cfg.seg1} + 5'h01 + {2'h0, s_r.seg1Extra};
	assign seg2Len = {2'h0, s_r.cfg.seg2} + 5'h01;
	assign seg2Limit = seg2Len - {2'h0, s_r.seg2Cut};
	// majority only with a prescale above zero
	assign useMajority = s_r.cfg.sam && (s_r.cfg.brp != 8'h00);
	assign fall = s_r.rxPrev && !s_r.rxSync;
	assign hardSync = fall && hardSyncEn;
	assign seg2Clks = 12'(seg2Len) * 12'({1'b0, s_r.cfg.brp} + 9'h001);

	cbt_prescaler #(
		.BRP_W(8)
	) u_presc (
		.clk(clk),
		.resetn(resetn),
		.restart(hardSync),
		.brp(s_r.cfg.brp),
		.tick(tqTick)
	);

	cbt_sampler u_samp (
		.clk(clk),
		.resetn(resetn),
		.shiftEn(tqTick),
		.rxIn(s_r.rxSync),
		.vote(vote)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.samplePulse = 1'b0;
		s_nxt.bitStart = 1'b0;
		// Pin passes two flops before any logic looks at it
		s_nxt.rxMeta = canRx;
		s_nxt.rxSync = s_r.rxMeta;
		s_nxt.rxPrev = s_r.rxSync;

		// jump width in the high configuration byte
		if (wrStb) begin
			unique case (addr)
				cbt_pkg::ADDR_PRESCALE: s_nxt.cfg.brp = wrData;
				cbt_pkg::ADDR_TWO_LOW: begin
					s_nxt.cfg.sam = wrData[cbt_pkg::SAM_POS];
					s_nxt.cfg.seg2 = wrData[cbt_pkg::SEG2_LSB +: 3];
					s_nxt.cfg.seg1 = wrData[cbt_pkg::SEG1_LSB +: 4];
				end
				cbt_pkg::ADDR_TWO_HIGH: begin
					s_nxt.cfg.resync_jump_width = wrData[cbt_pkg::SJW_LSB +: 2];
				end
				default: s_nxt.cfg = s_r.cfg;
			endcase
		end
		s_nxt.rdData = rdStb ? readMux(s_r, addr) : 8'h00;

		// second segment must hold the processing time
		// baud rate is clock over prescale plus one times bit quanta
		s_nxt.cfgBad = (s_r.cfg.seg1 < {1'b0, s_r.cfg.seg2})
			|| (seg2Clks < 12'(cbt_pkg::IPT_CYCLES))
			|| ((s_r.cfg.brp == 8'h00)
				? (seg2Len < 5'(cbt_pkg::SEG2_MIN_NO_PRESCALE))
				: (seg2Len < 5'(cbt_pkg::SEG2_MIN)))
			|| ({2'h0, sjwQ} >= seg2Len);

		// An edge that meets a tick waits one cycle; with prescale zero every cycle ticks, so it waits for good
		s_nxt.pendEdge = (fall && !hardSync) || (s_r.pendEdge && tqTick);

		if (hardSync) begin
			// Edge quantum counts as the sync segment
			s_nxt.phase = cbt_pkg::CBT_SEG1;
			s_nxt.cnt = 5'h00;
			s_nxt.seg1Extra = 3'h0;
			s_nxt.seg2Cut = 3'h0;
			s_nxt.resynced = 1'b1;
			s_nxt.bitStart = 1'b1;
			s_nxt.pendEdge = 1'b0;
		end else if (tqTick) begin
			unique case (s_r.phase)
				cbt_pkg::CBT_SYNC: begin
					s_nxt.phase = cbt_pkg::CBT_SEG1;
					s_nxt.cnt = 5'h00;
					s_nxt.bitStart = 1'b1;
				end
				// sample at end of first segment
				cbt_pkg::CBT_SEG1: begin
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (s_r.cnt + 5'h01 >= seg1Limit) begin
						s_nxt.phase = cbt_pkg::CBT_SEG2;
						s_nxt.cnt = 5'h00;
						s_nxt.samplePulse = 1'b1;
						s_nxt.rxBit = useMajority ? vote : s_r.rxSync;
					end
				end
				cbt_pkg::CBT_SEG2: begin
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (s_r.cnt + 5'h01 >= seg2Limit) begin
						s_nxt.phase = cbt_pkg::CBT_SYNC;
						s_nxt.cnt = 5'h00;
						s_nxt.seg1Extra = 3'h0;
						s_nxt.seg2Cut = 3'h0;
						s_nxt.resynced = 1'b0;
					end
				end
			endcase
		end else if (s_r.pendEdge && !s_r.resynced && s_r.rxBit) begin
			// correction capped at the jump width
			unique case (s_r.phase)
				cbt_pkg::CBT_SEG1: begin
					s_nxt.seg1Extra = minQ(s_r.cnt + 5'h01, sjwQ);
					s_nxt.resynced = 1'b1;
				end
				cbt_pkg::CBT_SEG2: begin
					s_nxt.seg2Cut = minQ(seg2Len - s_r.cnt - 5'h01, sjwQ);
					s_nxt.resynced = 1'b1;
				end
				cbt_pkg::CBT_SYNC: s_nxt.resynced = s_r.resynced;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.cfg.brp <= cbt_pkg::PRESCALE_RST;
			s_r.cfg.sam <= cbt_pkg::TWO_LOW_RST[cbt_pkg::SAM_POS];
			s_r.cfg.seg2 <= cbt_pkg::TWO_LOW_RST[cbt_pkg::SEG2_LSB +: 3];
			s_r.cfg.seg1 <= cbt_pkg::TWO_LOW_RST[cbt_pkg::SEG1_LSB +: 4];
			s_r.cfg.resync_jump_width <= cbt_pkg::TWO_HIGH_RST[cbt_pkg::SJW_LSB +: 2];
			s_r.rxMeta <= 1'b1;
			s_r.rxSync <= 1'b1;
			s_r.rxPrev <= 1'b1;
			s_r.rxBit <= 1'b1;
			s_r.phase <= cbt_pkg::CBT_SYNC;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdData = s_r.rdData;
	assign rxBit = s_r.rxBit;
	assign samplePulse = s_r.samplePulse;
	assign bitStart = s_r.bitStart;

	AST_SYNC_ONE_TQ: assert property (@(posedge clk) disable iff (!resetn)
		(s_r.phase == cbt_pkg::CBT_SYNC && tqTick && !hardSync)
		|=> (s_r.phase == cbt_pkg::CBT_SEG1 && bitStart && s_r.cnt == 5'h00))
		else $error("sync segment did not last one quantum");

	AST_SEG1_LEN: assert property (@(posedge clk) disable iff (!resetn)
		(s_r.phase == cbt_pkg::CBT_SEG1 && tqTick && !hardSync
			&& s_r.cnt + 5'h01 == seg1Limit)
		|=> (samplePulse && s_r.phase == cbt_pkg::CBT_SEG2))
		else $error("sample point not at end of first segment");

	AST_SJW_LIMIT: assert property (@(posedge clk) disable iff (!resetn)
		(s_r.seg1Extra <= sjwQ) && (s_r.seg2Cut <= sjwQ))
		else $error("phase correction beyond the jump width");

	AST_LATE_EDGE: assert property (@(posedge clk) disable iff (!resetn)
		(s_r.phase == cbt_pkg::CBT_SEG1 && s_r.pendEdge && !tqTick
			&& !hardSync && !s_r.resynced && s_r.rxBit)
		|=> (s_r.seg1Extra != 3'h0 && s_r.resynced))
		else $error("late edge did not lengthen first segment");

	AST_FALL_ONLY: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s_r.pendEdge) |-> $past(s_r.rxPrev && !s_r.rxSync))
		else $error("resync edge without a falling bus edge");

	AST_SINGLE_SAMPLE: assert property (@(posedge clk) disable iff (!resetn)
		(samplePulse && $past(!useMajority)) |-> (rxBit == $past(s_r.rxSync)))
		else $error("single sampling not used");

	AST_MAJORITY: assert property (@(posedge clk) disable iff (!resetn)
		(samplePulse && $past(useMajority)) |-> (rxBit == $past(vote)))
		else $error("majority vote not used at sample point");

	AST_IPT_FLAG: assert property (@(posedge clk) disable iff (!resetn)
		(seg2Clks < 12'h004) |=> s_r.cfgBad)
		else $error("short second segment not flagged");

	AST_SJW_FIELD: assert property (@(posedge clk) disable iff (!resetn)
		(wrStb && addr == cbt_pkg::ADDR_TWO_HIGH)
		|=> (s_r.cfg.resync_jump_width == $past(wrData[1:0])))
		else $error("jump width field not written");
endmodule
`default_nettype wire

// ==== cbt_can_node.sv ====
`timescale 1ns/1ps
`default_nettype none
// Other nodes on the wired-AND bus; recessive by pull-up when none drives
module cbt_can_node (
	// Dominant request from the scenario, set in the device's bit slots
	input wire logic domReq,
	// Shared bus level
	output logic canRx
);
	assign canRx = domReq ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== test_can_bit_timing_logic.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_can_bit_timing_logic;
	logic clk, resetn, wrStb, rdStb, canRx, hardSyncEn, domReq;
	logic rxBit, samplePulse, bitStart;
	logic [15:0] addr;
	logic [7:0] wrData, rdData, rd;
	int errors = 0, nTests = 0, cyc = 0, t0, j;
	int pTab [3] = '{0, 1, 3};
	int s1Tab [3] = '{6, 2, 7};
	int s2Tab [3] = '{3, 1, 4};

	cbt_bit_timing dut_u (.clk(clk), .resetn(resetn), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.canRx(canRx), .hardSyncEn(hardSyncEn), .rxBit(rxBit),
		.samplePulse(samplePulse), .bitStart(bitStart));
	cbt_can_node node_u (.domReq(domReq), .canRx(canRx));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Hang guard, well above the expected few thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			summarize();
		end
	end

	task summarize;
		$display("tests %0d errors %0d", nTests, errors);
		if (errors == 0 && nTests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp,
			input string m);
		nTests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %0h expected %0h",
				$time, m, got, exp);
		end
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask

	task rdr(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 d = rdData;
	endtask

	// Bounded wait for a bit start (0) or a sample point (1)
	task waitPulse(input bit smp);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while ((smp ? samplePulse : bitStart) !== 1'b1 && k < 2000);
		if (k >= 2000)
			check(16'h0000, 16'h0001, "pulse missing");
	endtask

	task cfg(input int p, input int s1, input int s2, input logic sam,
			input logic [1:0] jw);
		wr(cbt_pkg::ADDR_PRESCALE, p[7:0]);
		wr(cbt_pkg::ADDR_TWO_LOW, {sam, s2[2:0], s1[3:0]});
		wr(cbt_pkg::ADDR_TWO_HIGH, {6'h00, jw});
		waitPulse(0);
	endtask

	initial begin
		resetn = 1'b0;
		wrStb = 1'b0;
		rdStb = 1'b0;
		addr = 16'h0000;
		wrData = 8'h00;
		hardSyncEn = 1'b0;
		domReq = 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rdr(cbt_pkg::ADDR_TWO_HIGH, rd);
		check({8'h00, rd}, 16'h0000, "jump width reset");
		rdr(cbt_pkg::ADDR_PRESCALE, rd);
		check({8'h00, rd}, 16'h0000, "prescale reset");
		@(posedge clk);
		#1 check({8'h00, rdData}, 16'h0000, "read data one cycle");
		rdr(cbt_pkg::ADDR_STATUS, rd);
		check({15'h0000, rd[4]}, 16'h0001, "reset config flagged");
		wr(cbt_pkg::ADDR_TWO_HIGH, 8'hFF);
		rdr(cbt_pkg::ADDR_TWO_HIGH, rd);
		check({8'h00, rd}, 16'h0003, "jump width field");
		// Unmapped place must ignore writes and read zero
		wr(16'h2320, 8'h5A);
		rdr(16'h2320, rd);
		check({8'h00, rd}, 16'h0000, "unmapped read");
		$display("register test done");
		for (j = 0; j < 3; j++) begin
			cfg(pTab[j], s1Tab[j], s2Tab[j], 1'b0, 2'h0);
			waitPulse(0);
			t0 = cyc;
			waitPulse(1);
			check(16'(cyc - t0), 16'((pTab[j] + 1) * (s1Tab[j] + 1)),
				"sample offset");
			waitPulse(0);
			check(16'(cyc - t0),
				16'((pTab[j] + 1) * (s1Tab[j] + s2Tab[j] + 3)),
				"bit period");
		end
		$display("bit period test done");
		// Quantum of 4 clocks, 14 quanta a bit
		cfg(3, 7, 4, 1'b0, 2'h0);
		rdr(cbt_pkg::ADDR_STATUS, rd);
		check({15'h0000, rd[4]}, 16'h0000, "legal config");
		for (j = 0; j < 4; j++) begin
			wr(cbt_pkg::ADDR_TWO_HIGH, {6'h00, j[1:0]});
			waitPulse(0);
			waitPulse(0);
			t0 = cyc;
			repeat (20) @(posedge clk);
			domReq <= 1'b1;
			waitPulse(0);
			check(16'(cyc - t0), 16'(56 + 4 * (j + 1)),
				"late edge");
			t0 = cyc;
			repeat (8) @(posedge clk);
			domReq <= 1'b0;
			waitPulse(0);
			check(16'(cyc - t0), 16'd56, "rising edge");
		end
		$display("resync test done");
		// One-quantum recessive glitch over the sample point
		for (j = 0; j < 2; j++) begin
			cfg(3, 7, 4, j[0], 2'h0);
			@(posedge clk);
			domReq <= 1'b1;
			waitPulse(0);
			waitPulse(0);
			repeat (27) @(posedge clk);
			domReq <= 1'b0;
			repeat (4) @(posedge clk);
			domReq <= 1'b1;
			waitPulse(1);
			check({15'h0000, rxBit}, 16'(1 - j), "vote");
			@(posedge clk);
			domReq <= 1'b0;
		end
		// Hard sync restarts the bit three clocks after the bus falls
		hardSyncEn <= 1'b1;
		waitPulse(0);
		t0 = cyc;
		repeat (10) @(posedge clk);
		domReq <= 1'b1;
		waitPulse(0);
		check(16'(cyc - t0), 16'd13, "hard sync");
		hardSyncEn <= 1'b0;
		domReq <= 1'b0;
		$display("sampling test done");
		summarize();
	end
endmodule
`default_nettype wire
